// >>> core/vrlc_top.sv
// Purpose: APB register bank steering the reference ladder
// Assumes: Single pclk domain; zero-wait-state APB slave
// Notes:   Ladder outputs are registered copies of the decoded word
`timescale 1ns/100ps
`default_nettype none
module vrlc_top
    import vrlc_pkg::*;
(
    // APB slave side, all on pclk
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [VRLC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Ladder settings, each straight from a flip-flop
    output logic                        ref_enable,
    output logic                        ref_pin_output_enable,
    output logic                        ref_range_select,
    output logic                        ref_source_select,
    output logic      [VRLC_LVL_W-1:0]  ref_level_select
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]  ctrl;
        logic [31:0]  rdata;
        logic         slverr;
        vrlc_ladder_t lad;
    } vrlc_state_t;

    vrlc_state_t  s_q;
    vrlc_state_t  s_d;
    vrlc_op_t     op;
    logic         hit;
    logic         wr_ok;
    logic [31:0]  ctrl_nxt;
    vrlc_ladder_t lad_nxt;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic vrlc_mapped(input logic [VRLC_ADDR_W-1:0] a);
        vrlc_mapped = (a == VRLC_OFS_CTRL) || (a == VRLC_OFS_CLR) ||
                      (a == VRLC_OFS_SET)  || (a == VRLC_OFS_INV);
    endfunction

    always_comb begin
        unique case (paddr)
            VRLC_OFS_CLR: op = VRLC_OP_CLEAR;
            VRLC_OFS_SET: op = VRLC_OP_SET;
            VRLC_OFS_INV: op = VRLC_OP_INV;
            default:      op = VRLC_OP_WRITE;
        endcase
    end

    assign hit   = vrlc_mapped(paddr);
    // Partial-word writes are refused: every bank access is a full word
    assign wr_ok = psel & penable & pwrite & hit & (pstrb == 4'hF);

    // ----------------------------------------------------------------
    // Word update and ladder decode
    // ----------------------------------------------------------------
    // The decoder reads the next word, so the ladder flops move on the
    // same edge as the word and never show a stale setting
    vrlc_bitop u_bitop (
        .cur   (s_q.ctrl),
        .wdata (pwdata),
        .op    (op),
        .nxt   (ctrl_nxt)
    );

    vrlc_decode u_decode (
        .ctrl (s_d.ctrl),
        .lad  (lad_nxt)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.slverr = 1'b0;
        // No power-mode input exists: the word changes only by bus writes
        if (wr_ok) begin
            s_d.ctrl = ctrl_nxt;
        end
        // Read data and error are captured in the setup cycle, so both
        // stand from flip-flops through the whole access phase
        if (psel & ~penable) begin
            if (!hit) begin
                s_d.rdata  = 32'h00000000;
                s_d.slverr = 1'b1;
            end else if (paddr == VRLC_OFS_CTRL) begin
                s_d.rdata = s_q.ctrl & VRLC_IMPL_MASK;
            end else begin
                s_d.rdata = VRLC_ALIAS_RD;
            end
            if (pwrite && hit && pstrb != 4'hF) begin
                s_d.slverr = 1'b1;
            end
        end
        s_d.lad = lad_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready                = 1'b1;
    assign prdata                = s_q.rdata;
    assign pslverr               = s_q.slverr;
    assign ref_enable            = s_q.lad.on;
    assign ref_pin_output_enable = s_q.lad.pin_oe;
    assign ref_range_select      = s_q.lad.range_low;
    assign ref_source_select     = s_q.lad.src_ext;
    assign ref_level_select      = s_q.lad.level;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_on_set_keeps: assert property (
        wr_ok && op == VRLC_OP_SET && pwdata[VRLC_BIT_ON]
        |=> s_q.ctrl[VRLC_BIT_ON] &&
            ((s_q.ctrl ^ $past(s_q.ctrl)) & ~$past(pwdata)) == 32'h00000000)
        else $error("set of on bit disturbed other bits");
    a_off_keeps: assert property (
        wr_ok && op == VRLC_OP_CLEAR && pwdata[VRLC_BIT_ON]
        |=> !s_q.ctrl[VRLC_BIT_ON] &&
            ((s_q.ctrl ^ $past(s_q.ctrl)) & ~$past(pwdata)) == 32'h00000000)
        else $error("clear of on bit disturbed other bits");
    a_clear_op: assert property (
        wr_ok && op == VRLC_OP_CLEAR
        |=> s_q.ctrl == ($past(s_q.ctrl) & ~$past(pwdata) & VRLC_IMPL_MASK))
        else $error("clear alias wrong");
    a_set_op: assert property (
        wr_ok && op == VRLC_OP_SET
        |=> s_q.ctrl == (($past(s_q.ctrl) | $past(pwdata)) & VRLC_IMPL_MASK))
        else $error("set alias wrong");
    a_inv_op: assert property (
        wr_ok && op == VRLC_OP_INV
        |=> s_q.ctrl == (($past(s_q.ctrl) ^ $past(pwdata)) & VRLC_IMPL_MASK))
        else $error("invert alias wrong");
    a_resv_zero: assert property (
        (s_q.ctrl & ~VRLC_IMPL_MASK) == 32'h00000000)
        else $error("reserved control bit set");
    a_hold_idle: assert property (
        !wr_ok |=> $stable(s_q.ctrl))
        else $error("control changed without a write");
    a_pin_gate: assert property (
        ref_pin_output_enable ==
            (s_q.ctrl[VRLC_BIT_ON] && s_q.ctrl[VRLC_BIT_OE]))
        else $error("pin enable out of step");
    a_level_out: assert property (
        ##1 ref_level_select == s_q.ctrl[3:0])
        else $error("level output mismatch");
    a_range_out: assert property (
        ref_range_select == s_q.ctrl[VRLC_BIT_RANGE] &&
        ref_source_select == s_q.ctrl[VRLC_BIT_SRC])
        else $error("range or source output mismatch");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    c_turn_on: cover property (wr_ok && op == VRLC_OP_SET ##1 ref_enable);
    c_invert: cover property (wr_ok && op == VRLC_OP_INV);
    c_pin_on: cover property (ref_pin_output_enable);
    c_unmapped: cover property (psel && penable && pslverr);
    c_refused: cover property (psel && penable && pwrite && pslverr);

    // ----------------------------------------------------------------
    // Bus checks
    // ----------------------------------------------------------------
    // Read data and error are judged one edge after the setup cycle
    a_ctrl_read: assert property (
        psel && !penable && !pwrite && paddr == VRLC_OFS_CTRL
        |=> prdata == $past(s_q.ctrl))
        else $error("control read returned a stale word");
    a_alias_read: assert property (
        psel && !penable && hit && paddr != VRLC_OFS_CTRL
        |=> prdata == VRLC_ALIAS_RD)
        else $error("alias read returned an unexpected word");
    a_unmapped_err: assert property (
        psel && !penable && !hit
        |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not flagged");
    a_strb_err: assert property (
        psel && !penable && pwrite && pstrb != 4'hF
        |=> pslverr)
        else $error("partial write not flagged");
    a_strb_keep: assert property (
        psel && penable && pwrite && pstrb != 4'hF
        |=> s_q.ctrl == $past(s_q.ctrl))
        else $error("partial write changed the control word");
    a_err_access: assert property (
        pslverr |-> psel && penable)
        else $error("error response outside an access phase");
    a_err_pulse: assert property (
        pslverr |=> !pslverr)
        else $error("error response held past its access phase");
    a_rdata_hold: assert property (
        !(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside a setup cycle");
    a_ready_high: assert property (
        pready)
        else $error("ready dropped");
    a_dir_write: assert property (
        wr_ok && op == VRLC_OP_WRITE
        |=> s_q.ctrl == ($past(pwdata) & VRLC_IMPL_MASK))
        else $error("direct write did not land");
    a_op_decode: assert property (
        psel && paddr == VRLC_OFS_INV |-> op == VRLC_OP_INV)
        else $error("invert alias not decoded");

    // ----------------------------------------------------------------
    // Output checks
    // ----------------------------------------------------------------
    a_on_out: assert property (
        ref_enable == s_q.ctrl[VRLC_BIT_ON])
        else $error("enable output out of step");
    a_pin_off: assert property (
        !ref_enable |-> !ref_pin_output_enable)
        else $error("pin driven while the reference is off");
    a_on_direct: assert property (
        wr_ok && op == VRLC_OP_WRITE
        |=> ref_enable == $past(pwdata[VRLC_BIT_ON]))
        else $error("direct write of the on bit not applied");
    a_out_hold: assert property (
        !wr_ok |=> $stable({ref_enable, ref_pin_output_enable,
                            ref_range_select, ref_source_select,
                            ref_level_select}))
        else $error("ladder outputs moved without a write");

    // ----------------------------------------------------------------
    // Reset checks
    // ----------------------------------------------------------------
    // Judged as reset lets go, so the reset itself does not mask it
    a_reset_clear: assert property (
        disable iff (1'b0)
        $rose(presetn) |-> s_q.ctrl == 32'h00000000 && !ref_enable &&
            !ref_pin_output_enable && prdata == 32'h00000000)
        else $error("reset left the control word set");

    // ----------------------------------------------------------------
    // Per-bit alias checks
    // ----------------------------------------------------------------
    // Each bit judged alone, so a fault in the word-wide mask shows here
    for (genvar b = 0; b < 32; b++) begin : g_bit
        if (VRLC_IMPL_MASK[b]) begin : g_impl
            a_bit_set: assert property (
                wr_ok && op == VRLC_OP_SET && pwdata[b] |=> s_q.ctrl[b])
                else $error("set alias missed a bit");
            a_bit_clear: assert property (
                wr_ok && op == VRLC_OP_CLEAR && pwdata[b] |=> !s_q.ctrl[b])
                else $error("clear alias missed a bit");
            a_bit_flip: assert property (
                wr_ok && op == VRLC_OP_INV && pwdata[b]
                |=> s_q.ctrl[b] != $past(s_q.ctrl[b]))
                else $error("invert alias missed a bit");
            a_bit_keep: assert property (
                wr_ok && op != VRLC_OP_WRITE && !pwdata[b]
                |=> s_q.ctrl[b] == $past(s_q.ctrl[b]))
                else $error("alias write disturbed an unselected bit");
        end else begin : g_resv
            a_bit_resv: assert property (
                wr_ok |=> !s_q.ctrl[b])
                else $error("write reached a reserved bit");
        end
    end
endmodule
`default_nettype wire

// >>> core/vrlc_pkg.sv
// Purpose: Constants and types for the voltage reference control bank
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Function list follows
//
// Function
// - Writing one to bit 15 via the set alias turns the reference on, other bits kept.
// - Writing one to bit 15 via the clear alias powers the reference down, others kept.
// - Bit 6 connects the level to the pin, overriding pin direction.
// - Bit 5 picks low range (n/24) or high range (1/4 + n/32).
// - Bit 4 picks external reference pins or analog supply rails.
// - Bits 3 to 0 select one of sixteen ladder taps.
// - Clear alias zeroes each control bit written with one.
// - Set alias forces to one each control bit written with one.
// - Invert alias toggles each control bit written with one.
// - Alias writes never touch unimplemented bit positions.
// - Alias reads return an undefined value; software avoids them.
// - Every reset forces all control bits to zero.
// - Control stays unchanged through sleep, idle and debug halt.
package vrlc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  VRLC_OFS_CTRL  = 8'h00;
    localparam logic [7:0]  VRLC_OFS_CLR   = 8'h04;
    localparam logic [7:0]  VRLC_OFS_SET   = 8'h08;
    localparam logic [7:0]  VRLC_OFS_INV   = 8'h0C;
    localparam int          VRLC_ADDR_W    = 8;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int          VRLC_BIT_ON    = 15;
    localparam int          VRLC_BIT_OE    = 6;
    localparam int          VRLC_BIT_RANGE = 5;
    localparam int          VRLC_BIT_SRC   = 4;
    localparam int          VRLC_LVL_LSB   = 0;
    localparam int          VRLC_LVL_W     = 4;
    localparam logic [31:0] VRLC_IMPL_MASK = 32'h0000807F;
    localparam logic [31:0] VRLC_CTRL_RST  = 32'h00000000;
    localparam logic [31:0] VRLC_ALIAS_RD  = 32'h00000000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        VRLC_OP_WRITE = 2'b00,
        VRLC_OP_CLEAR = 2'b01,
        VRLC_OP_SET   = 2'b10,
        VRLC_OP_INV   = 2'b11
    } vrlc_op_t;

    typedef struct packed {
        logic                  on;
        logic                  pin_oe;
        logic                  range_low;
        logic                  src_ext;
        logic [VRLC_LVL_W-1:0] level;
    } vrlc_ladder_t;

endpackage

// >>> core/vrlc_bitop.sv
// Purpose: Applies a direct, clear, set or invert write to the control word
// Assumes: Caller gates with a qualified write
// Notes:   Unimplemented positions always come out zero
`timescale 1ns/100ps
`default_nettype none
module vrlc_bitop
    import vrlc_pkg::*;
(
    input  wire logic [31:0] cur,
    input  wire logic [31:0] wdata,
    input  wire vrlc_op_t    op,
    output logic      [31:0] nxt
);
    logic [31:0] raw;

    always_comb begin
        unique case (op)
            VRLC_OP_WRITE: raw = wdata;
            VRLC_OP_CLEAR: raw = cur & ~wdata;
            VRLC_OP_SET:   raw = cur | wdata;
            VRLC_OP_INV:   raw = cur ^ wdata;
        endcase
        // Masking here keeps reserved bits zero whatever software writes
        nxt = raw & VRLC_IMPL_MASK;
    end
endmodule
`default_nettype wire

// >>> core/vrlc_decode.sv
// Purpose: Splits the control word into ladder settings
// Assumes: Pure combinational
// Notes:   Pin enable gated off while the reference is powered down; level passes ungated
`timescale 1ns/100ps
`default_nettype none
module vrlc_decode
    import vrlc_pkg::*;
(
    input  wire logic [31:0] ctrl,
    output vrlc_ladder_t     lad
);
    always_comb begin
        lad.on        = ctrl[VRLC_BIT_ON];
        lad.pin_oe    = ctrl[VRLC_BIT_ON] & ctrl[VRLC_BIT_OE];
        lad.range_low = ctrl[VRLC_BIT_RANGE];
        lad.src_ext   = ctrl[VRLC_BIT_SRC];
        lad.level     = ctrl[VRLC_LVL_LSB +: VRLC_LVL_W];
    end
endmodule
`default_nettype wire

// >>> tb/vrlc_ladder_model.sv
// Purpose: Behavioural ladder tap selector facing the comparators
// Assumes: Settings arrive as registered levels from the bank
// Notes:   Tap value is in units of one ninety-sixth of the source
`timescale 1ns/100ps
`default_nettype none
module vrlc_ladder_model
    import vrlc_pkg::*;
(
    input  wire logic                  ref_enable,
    input  wire logic                  ref_pin_output_enable,
    input  wire logic                  ref_range_select,
    input  wire logic [VRLC_LVL_W-1:0] ref_level_select,
    output logic      [6:0]            comparator_reference,
    output logic                       pin_drive
);
    // Powered down ladder gives nothing, so a stuck enable shows up
    always_comb begin
        if (!ref_enable) begin
            comparator_reference = 7'h00;
        end else if (ref_range_select) begin
            comparator_reference = 7'(ref_level_select) * 7'h04;
        end else begin
            comparator_reference = 7'h18 + 7'(ref_level_select) * 7'h03;
        end
    end
    assign pin_drive = ref_enable & ref_pin_output_enable;
endmodule
`default_nettype wire

// >>> tb/vrlc_top_tb.sv
// Purpose: Self-checking bench for the reference control bank
// Assumes: APB master tasks, ladder model on the outputs
// Notes:   Byte strobes full except one partial write; expected words built from bit layout
`timescale 1ns/100ps
`default_nettype none
module vrlc_top_tb
    import vrlc_pkg::*;
;
    logic                   pclk, presetn, psel, penable, pwrite;
    logic [VRLC_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, rd, w;
    logic [3:0]             pstrb;
    logic                   pready, pslverr, err, r_en, r_oe, r_rng;
    logic                   r_src, pin_drv;
    logic [VRLC_LVL_W-1:0]  r_lvl;
    logic [6:0]             cref;
    int                     n_errors, cmp_count;

    vrlc_top vrlc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_enable(r_en),
        .ref_pin_output_enable(r_oe), .ref_range_select(r_rng),
        .ref_source_select(r_src), .ref_level_select(r_lvl));
    vrlc_ladder_model vrlc_ladder_model_inst (.ref_enable(r_en),
        .ref_pin_output_enable(r_oe), .ref_range_select(r_rng),
        .ref_level_select(r_lvl), .comparator_reference(cref),
        .pin_drive(pin_drv));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Request held until pready is seen high, then released; the idle
    // edge at the top spaces each access from the one before
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int   n;
        logic rdy;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            // Outputs move only on rising edges: what stands here is
            // what the next rising edge samples
            @(negedge pclk);
            rdy = pready;
            rd  = prdata;
            err = pslverr;
            @(posedge pclk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            n_errors++;
            test_done();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] e);
        apb(1'b1, a, d);
        apb(1'b0, VRLC_OFS_CTRL, 32'h0);
        chk("ctrl", rd, e);
        chk("outs", {24'h0, r_en, r_oe, r_rng, r_src, r_lvl},
            {24'h0, e[15], e[15] & e[6], e[5], e[4], e[3:0]});
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        cmp_count = 0;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wr_chk(VRLC_OFS_INV, 32'h0, VRLC_CTRL_RST);
        wr_chk(VRLC_OFS_CTRL, 32'h0000007F, 32'h0000007F);
        wr_chk(VRLC_OFS_SET, 32'h00008000, 32'h0000807F);
        wr_chk(VRLC_OFS_CLR, 32'h00008001, 32'h0000007E);
        wr_chk(VRLC_OFS_CLR, 32'h0000000C, 32'h00000072);
        wr_chk(VRLC_OFS_SET, 32'h0000800D, 32'h0000807F);
        wr_chk(VRLC_OFS_INV, 32'h0000803F, 32'h00000040);
        wr_chk(VRLC_OFS_SET, 32'hFFFFFFFF, 32'h0000807F);
        wr_chk(VRLC_OFS_INV, 32'hFFFF7F80, 32'h0000807F);
        for (int k = 1; k < 4; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk("alias_rd", rd, VRLC_ALIAS_RD);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {rd[31:1], err}, 32'h1);
        pstrb <= 4'h3;
        apb(1'b1, VRLC_OFS_CTRL, 32'h0);
        pstrb <= 4'hF;
        chk("strb_err", {31'h0, err}, 32'h1);
        apb(1'b0, VRLC_OFS_CTRL, 32'h0);
        chk("strb_keep", rd, 32'h0000807F);
        for (int i = 0; i < 32; i++) begin
            w = 32'h8000 | 32'(i[3:0]) | (i[4] ? 32'h0 : 32'h20)
                | (i[0] ? 32'h50 : 32'h0);
            wr_chk(VRLC_OFS_CTRL, w, w);
            chk("tap", {25'h0, cref}, w[5] ? 32'(w[3:0]) * 4
                : 32'h18 + 32'(w[3:0]) * 3);
            chk("pin", {31'h0, pin_drv}, {31'h0, w[6]});
        end
        repeat (100) @(posedge pclk);
        wr_chk(VRLC_OFS_SET, 32'h0, w);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr_chk(VRLC_OFS_CLR, 32'h0, VRLC_CTRL_RST);
        test_done();
    end
endmodule
`default_nettype wire
